// ---- logic/bfoc_pkg.sv ----
package bfoc_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned LOCK_MS         = 100;
   localparam int unsigned LOCK_CYC        = (CLK_HZ / 1000) * LOCK_MS;
   localparam int unsigned STARTUP_MS      = 500;
   localparam int unsigned STARTUP_CYC     = (CLK_HZ / 1000) * STARTUP_MS;
   localparam int unsigned LOCK_TONE_HZ    = 350;
   localparam int unsigned LOCK_DUTY_PCT   = 15;
   localparam int unsigned LOCK_PER_CYC    = CLK_HZ / LOCK_TONE_HZ;
   localparam int unsigned LOCK_HI_CYC     = (LOCK_PER_CYC * LOCK_DUTY_PCT) / 100;
   localparam int unsigned HOT_TONE_HZ     = 770;
   localparam int unsigned HOT_DUTY_PCT    = 13;
   localparam int unsigned HOT_PER_CYC     = CLK_HZ / HOT_TONE_HZ;
   localparam int unsigned HOT_HI_CYC      = (HOT_PER_CYC * HOT_DUTY_PCT) / 100;
   localparam int unsigned OFF_UNIT_CYC    = 256;

   // ************************************************************
   // Reset values and widths
   // ************************************************************
   localparam logic [7:0]  HOT_LIMIT_RST   = 8'h99;
   localparam logic [7:0]  OFF_STEP_RST    = 8'h00;
   localparam int unsigned TEMP_W          = 8;
   localparam int unsigned TONE_W          = 17;

   typedef enum logic [1:0] {BFOC_STARTUP, BFOC_RUN, BFOC_LOCKED} bfoc_state_t;

   typedef struct packed {
      logic firstCoilDrive;
      logic secondCoilDrive;
      logic alarmDrive;
   } bfoc_drive_t;

   typedef struct packed {
      logic lockAlarm;
      logic hotAlarm;
      logic running;
   } bfoc_status_t;

endpackage

// ---- logic/bfoc_fan_ctrl.sv ----
`timescale 1ns/10ps
// Functional notes
// - First coil drive switches on each falling Hall edge.
// - Second coil drive switches on each rising Hall edge.
// - Off-time is timed from Hall edges, never free running.
// - Full speed inserts no off-time; coil on for whole half-period.
// - Lower speed lengthens off-time and shortens on-time equally.
// - Falling Hall edges raise an edge event.
// - Rising Hall edges raise a capture event.
// - Same off-time from latest temperature reading for both phases.
// - Temperature maps to speed through a writable look-up table.
// - Locked rotor declared after no Hall activity beyond 100 ms.
// - On lock both coil drives turn off at once.
// - After stopping for lock the lock alarm becomes active.
// - Lock tone is 350 Hz at 15 percent duty.
// - Over-temperature tone is 770 Hz at 13 percent duty.
// - Over-temperature alarm at threshold; motor keeps running.
// - After lock, Hall ignored; stay stopped until power-on reset.
// - Start-up runs full power with zero off-time, then regulates.
module bfoc_fan_ctrl
   import bfoc_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES    = LOCK_CYC,
   parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic              clkEn,
   input  wire logic              hallIn,
   input  wire logic [TEMP_W-1:0] tempSample,
   input  wire logic              tempValid,
   input  wire logic [TEMP_W-1:0] hotLimit,
   input  wire logic              mapWrEn,
   input  wire logic [TEMP_W-1:0] mapWrAddr,
   input  wire logic [7:0]        mapWrData,
   output logic                   firstCoilDrive,
   output logic                   secondCoilDrive,
   output logic                   alarmSwitch,
   output logic                   lockAlarm,
   output logic                   hotAlarm
);

   if (LOCK_CYCLES < 2 || STARTUP_CYCLES < 1) begin : g_bad_counts
      $error("bfoc_fan_ctrl: counts too small");
   end

   // ************************************************************
   // Hall synchroniser and edge events
   // ************************************************************
   // Edges stay masked until the pipe holds real pin samples: the reset value
   // may differ from the idle pin level and would otherwise look like an edge
   logic       hallS1_q, hallS2_q, hallS3_q;
   logic [1:0] hallFill_q, hallFill_d;
   logic       fallEvt, riseEvt;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hallS1_q   <= 1'b0;
         hallS2_q   <= 1'b0;
         hallS3_q   <= 1'b0;
         hallFill_q <= 2'h0;
      end else if (clkEn) begin
         hallS1_q   <= hallIn;
         hallS2_q   <= hallS1_q;
         hallS3_q   <= hallS2_q;
         hallFill_q <= hallFill_d;
      end
   end

   always_comb begin
      hallFill_d = hallFill_q;
      if (hallFill_q != 2'h3) begin
         hallFill_d = hallFill_q + 2'h1;
      end
      fallEvt = clkEn && (hallFill_q == 2'h3) && hallS3_q && !hallS2_q;
      riseEvt = clkEn && (hallFill_q == 2'h3) && !hallS3_q && hallS2_q;
   end

   // ************************************************************
   // Temperature map
   // ************************************************************
   // Descending profile after reset (step = 255 - reading): hotter reading, lower step, faster fan
   logic [7:0]        map_q [256];
   logic [7:0]        map_d [256];
   logic [TEMP_W-1:0] temp_q, temp_d;
   logic [7:0]        offStep_q, offStep_d;

   always_comb begin
      map_d  = map_q;
      temp_d = temp_q;
      if (mapWrEn) begin
         map_d[mapWrAddr] = mapWrData;
      end
      if (tempValid) begin
         temp_d = tempSample;
      end
      offStep_d = map_q[temp_q];
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 256; i++) begin
            map_q[i] <= 8'(255 - i);
         end
         temp_q    <= 8'h00;
         offStep_q <= OFF_STEP_RST;
      end else if (clkEn) begin
         map_q     <= map_d;
         temp_q    <= temp_d;
         offStep_q <= offStep_d;
      end
   end

   // ************************************************************
   // Control state, lock watch and commutation
   // ************************************************************
   bfoc_state_t state_q, state_d;
   logic [31:0] lockCnt_q, lockCnt_d;
   logic [31:0] startCnt_q, startCnt_d;
   logic [15:0] offCnt_q, offCnt_d;
   logic [15:0] offLen_q, offLen_d;
   logic        phase_q, phase_d;
   logic        c1_q, c1_d, c2_q, c2_d;
   logic        hot_q, hot_d;

   always_comb begin
      state_d    = state_q;
      lockCnt_d  = lockCnt_q;
      startCnt_d = startCnt_q;
      offCnt_d   = offCnt_q;
      offLen_d   = offLen_q;
      phase_d    = phase_q;
      hot_d      = (temp_q >= hotLimit);
      unique case (state_q)
         BFOC_STARTUP, BFOC_RUN: begin
            if (fallEvt || riseEvt) begin
               lockCnt_d = '0;
               // Off-time is sampled per edge so both phases share one value
               offLen_d  = (state_q == BFOC_RUN) ? 16'(offStep_q) * 16'(OFF_UNIT_CYC) : 16'h0000;
               offCnt_d  = '0;
               phase_d   = fallEvt;
            end else begin
               lockCnt_d = lockCnt_q + 32'h0000_0001;
               if (offCnt_q != 16'hFFFF) begin
                  offCnt_d = offCnt_q + 16'h0001;
               end
            end
            if (state_q == BFOC_STARTUP) begin
               startCnt_d = startCnt_q + 32'h0000_0001;
               if (startCnt_q >= 32'(STARTUP_CYCLES - 1)) begin
                  state_d = BFOC_RUN;
               end
            end
            if (lockCnt_q >= 32'(LOCK_CYCLES - 1)) begin
               state_d = BFOC_LOCKED;
            end
         end
         BFOC_LOCKED: begin
            state_d = BFOC_LOCKED;
         end
         default: state_d = BFOC_LOCKED;
      endcase
      // Coil stays dark for offLen cycles after its edge, then on to next edge
      c1_d = (state_d != BFOC_LOCKED) && phase_d && (offCnt_d >= offLen_d);
      c2_d = (state_d != BFOC_LOCKED) && !phase_d && (offCnt_d >= offLen_d);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q    <= BFOC_STARTUP;
         lockCnt_q  <= '0;
         startCnt_q <= '0;
         offCnt_q   <= '0;
         offLen_q   <= '0;
         phase_q    <= 1'b1;
         c1_q       <= 1'b0;
         c2_q       <= 1'b0;
         hot_q      <= 1'b0;
      end else if (clkEn) begin
         state_q    <= state_d;
         lockCnt_q  <= lockCnt_d;
         startCnt_q <= startCnt_d;
         offCnt_q   <= offCnt_d;
         offLen_q   <= offLen_d;
         phase_q    <= phase_d;
         c1_q       <= c1_d;
         c2_q       <= c2_d;
         hot_q      <= hot_d;
      end
   end

   // ************************************************************
   // Alarm tones
   // ************************************************************
   // Lock tone wins over the hot tone; one transducer cannot carry both
   logic [TONE_W-1:0] toneCnt_q, toneCnt_d;
   logic              tone_q, tone_d;
   logic              lockA_q, lockA_d;
   logic [TONE_W-1:0] tonePer, toneHi;

   always_comb begin
      lockA_d = (state_q == BFOC_LOCKED);
      tonePer = lockA_q ? TONE_W'(LOCK_PER_CYC) : TONE_W'(HOT_PER_CYC);
      toneHi  = lockA_q ? TONE_W'(LOCK_HI_CYC) : TONE_W'(HOT_HI_CYC);
      if (!(lockA_q || hot_q) || toneCnt_q >= tonePer - 1'b1) begin
         toneCnt_d = '0;
      end else begin
         toneCnt_d = toneCnt_q + 1'b1;
      end
      // Compare the present count so the first burst after an alarm is full length
      tone_d = (lockA_q || hot_q) && (toneCnt_q < toneHi);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         toneCnt_q <= '0;
         tone_q    <= 1'b0;
         lockA_q   <= 1'b0;
      end else if (clkEn) begin
         toneCnt_q <= toneCnt_d;
         tone_q    <= tone_d;
         lockA_q   <= lockA_d;
      end
   end

   always_comb begin
      firstCoilDrive  = c1_q;
      secondCoilDrive = c2_q;
      alarmSwitch     = tone_q;
      lockAlarm       = lockA_q;
      hotAlarm        = hot_q;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence fallSeen_s;
      clkEn && fallEvt && state_q != BFOC_LOCKED && lockCnt_q < 32'(LOCK_CYCLES - 1);
   endsequence

   sequence riseSeen_s;
      clkEn && riseEvt && state_q != BFOC_LOCKED;
   endsequence

   hall_fall_a: assert property (clkEn && hallFill_q == 2'h3 && $fell(hallS2_q) |-> fallEvt)
      else $error("falling edge missed");
   hall_rise_a: assert property (clkEn && hallFill_q == 2'h3 && $rose(hallS2_q) |-> riseEvt)
      else $error("rising edge missed");
   coil_one_edge_a: assert property (fallSeen_s |=> phase_q) else $error("phase not set on fall");
   coil_two_edge_a: assert property (riseSeen_s |=> !phase_q)
      else $error("phase not cleared on rise");
   coil_one_drop_a: assert property (riseSeen_s |=> !firstCoilDrive)
      else $error("first coil on after rise");
   no_overlap_a: assert property (!(c1_q && c2_q)) else $error("both coils on");
   full_speed_a: assert property ((fallSeen_s and state_q == BFOC_STARTUP) |=> ##1 c1_q)
      else $error("startup off-time");
   full_run_a: assert property ((fallSeen_s and state_q == BFOC_RUN && offStep_q == 8'h00) |=> firstCoilDrive)
      else $error("off-time at full speed");
   off_restart_a: assert property (clkEn && (fallEvt || riseEvt) && state_q != BFOC_LOCKED |=> offCnt_q == 16'h0000)
      else $error("off-time not restarted");
   off_dark_a: assert property (offCnt_q < offLen_q |-> !firstCoilDrive && !secondCoilDrive)
      else $error("coil on during off-time");
   temp_take_a: assert property (clkEn && tempValid |=> temp_q == $past(tempSample))
      else $error("reading not taken");
   lock_due_a: assert property (clkEn && state_q != BFOC_LOCKED && lockCnt_q >= 32'(LOCK_CYCLES - 1)
      |=> state_q == BFOC_LOCKED) else $error("lock not declared");
   lock_early_a: assert property (clkEn && state_q != BFOC_LOCKED && lockCnt_q < 32'(LOCK_CYCLES - 1)
      |=> state_q != BFOC_LOCKED) else $error("lock declared early");
   lock_stop_a: assert property (state_q == BFOC_LOCKED |=> !c1_q && !c2_q) else $error("coil on when locked");
   lock_stay_a: assert property (state_q == BFOC_LOCKED |=> state_q == BFOC_LOCKED) else $error("left locked");
   lock_alarm_a: assert property (clkEn && state_q == BFOC_LOCKED |=> lockAlarm) else $error("no lock alarm");
   lock_count_a: assert property (clkEn && (fallEvt || riseEvt) && state_q != BFOC_LOCKED |=> lockCnt_q == 0)
      else $error("lock counter not cleared");

   // ************************************************************
   // Alarm checks
   // ************************************************************
   // The threshold is a live input, so the flag follows it within one cycle
   hot_raise_a: assert property (clkEn && temp_q >= hotLimit |=> hotAlarm)
      else $error("hot alarm missing");
   hot_clear_a: assert property (clkEn && temp_q < hotLimit |=> !hotAlarm)
      else $error("hot alarm stuck");
   lock_tone_a: assert property (clkEn && lockA_q && toneCnt_q < TONE_W'(LOCK_HI_CYC) |=> alarmSwitch)
      else $error("lock tone low");
   lock_gap_a: assert property (clkEn && lockA_q && toneCnt_q >= TONE_W'(LOCK_HI_CYC) |=> !alarmSwitch)
      else $error("lock tone high");
   hot_tone_a: assert property (clkEn && hot_q && !lockA_q && toneCnt_q < TONE_W'(HOT_HI_CYC) |=> alarmSwitch)
      else $error("hot tone low");
   hot_gap_a: assert property (clkEn && hot_q && !lockA_q && toneCnt_q >= TONE_W'(HOT_HI_CYC) |=> !alarmSwitch)
      else $error("hot tone high");
   tone_range_a: assert property (toneCnt_q < TONE_W'(HOT_PER_CYC) || lockA_q) else $error("tone period");
   quiet_a: assert property (!lockAlarm && !hotAlarm |=> !alarmSwitch) else $error("tone without alarm");

endmodule // bfoc_fan_ctrl

// ---- verif/bfoc_fan_model.sv ----
`timescale 1ns/10ps
// ************************************************************
// Rotor with Hall sensor
// ************************************************************
module bfoc_fan_model (
   input  wire logic        clk_sys,
   input  wire logic        spinEn,
   input  wire logic [15:0] halfPer,
   output logic             hallIn
);
   logic [15:0] cnt;
   initial begin
      hallIn = 1'b1;
      cnt    = 16'h0000;
   end
   // A stalled rotor holds its Hall level, so a lock shows no edges at all
   always @(posedge clk_sys) begin
      if (spinEn) begin
         cnt <= #1 (cnt >= halfPer - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
         if (cnt >= halfPer - 16'h0001) hallIn <= #1 ~hallIn;
      end
   end
endmodule // bfoc_fan_model

// ---- verif/test_bfoc_fan_ctrl.sv ----
`timescale 1ns/10ps
module test_bfoc_fan_ctrl;
   import bfoc_pkg::*;
   // Shortened counts; half turn stays below the lock time but above one off step
   localparam int unsigned LOCK = 2000;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        spinEn = 1'b0;
   logic        tempValid = 1'b0;
   logic        mapWrEn = 1'b0;
   logic [15:0] halfPer = 16'h0258;
   logic [7:0]  tempSample = 8'h00;
   logic [7:0]  hotLimit = 8'hFF;
   logic [7:0]  mapWrAddr = 8'h00;
   logic [7:0]  mapWrData = 8'h00;
   logic        hallIn, firstCoilDrive, secondCoilDrive, alarmSwitch, lockAlarm, hotAlarm;
   int          numErrors = 0;
   int          testsRun = 0;
   int          hi, per;

   always #12.5 clk_sys = ~clk_sys;

   bfoc_fan_ctrl #(.LOCK_CYCLES(LOCK), .STARTUP_CYCLES(1500)) i_dut (
      .clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1), .hallIn(hallIn),
      .tempSample(tempSample), .tempValid(tempValid), .hotLimit(hotLimit),
      .mapWrEn(mapWrEn), .mapWrAddr(mapWrAddr), .mapWrData(mapWrData),
      .firstCoilDrive(firstCoilDrive), .secondCoilDrive(secondCoilDrive),
      .alarmSwitch(alarmSwitch), .lockAlarm(lockAlarm), .hotAlarm(hotAlarm));
   bfoc_fan_model i_fan (.clk_sys(clk_sys), .spinEn(spinEn), .halfPer(halfPer), .hallIn(hallIn));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         numErrors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic coils(logic ef, logic es);
      check("firstCoilDrive", firstCoilDrive, ef);
      check("secondCoilDrive", secondCoilDrive, es);
   endtask
   task automatic afterEdge(logic fall, int n, logic ef, logic es);
      if (fall) @(negedge hallIn);
      else @(posedge hallIn);
      tick(n);
      coils(ef, es);
   endtask
   task automatic setTemp(logic [7:0] t);
      tempSample = t;
      tempValid = 1'b1;
      tick(1);
      tempValid = 1'b0;
   endtask
   // Called before the tone starts; counts the first burst, and with full set the whole period
   task automatic tone(bit full, output int h, output int p);
      int n;
      n = 0;
      h = 0;
      while (alarmSwitch !== 1'b1 && n < 200000) begin tick(1); n++; end
      while (alarmSwitch === 1'b1 && n < 200000) begin tick(1); n++; h++; end
      p = h;
      while (full && alarmSwitch !== 1'b1 && n < 200000) begin tick(1); n++; p++; end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic tStartup;
      setTemp(8'hFE);
      spinEn = 1'b1;
      afterEdge(1'b1, 8, 1'b1, 1'b0);
      afterEdge(1'b0, 8, 1'b0, 1'b1);
   endtask
   task automatic tOffTime;
      afterEdge(1'b1, 100, 1'b0, 1'b0);
      tick(200);
      coils(1'b1, 1'b0);
      afterEdge(1'b0, 100, 1'b0, 1'b0);
      tick(200);
      coils(1'b0, 1'b1);
      mapWrAddr = 8'h20;
      mapWrEn = 1'b1;
      tick(1);
      mapWrEn = 1'b0;
      setTemp(8'h20);
      afterEdge(1'b1, 8, 1'b1, 1'b0);
      afterEdge(1'b0, 8, 1'b0, 1'b1);
      check("hotAlarm", hotAlarm, 1'b0);
   endtask
   task automatic tHot;
      hotLimit = 8'h20;
      tone(1'b1, hi, per);
      check("hotHigh", hi, HOT_HI_CYC);
      check("hotPeriod", per, HOT_PER_CYC);
      check("hotAlarm", hotAlarm, 1'b1);
      afterEdge(1'b1, 8, 1'b1, 1'b0);
      hotLimit = 8'hFF;
      tick(4);
      check("hotAlarm", hotAlarm, 1'b0);
   endtask
   task automatic tLock;
      check("lockAlarm", lockAlarm, 1'b0);
      afterEdge(1'b1, 8, 1'b1, 1'b0);
      spinEn = 1'b0;
      tick(LOCK - 30);
      check("lockAlarm", lockAlarm, 1'b0);
      tone(1'b0, hi, per);
      check("lockHigh", hi, LOCK_HI_CYC);
      coils(1'b0, 1'b0);
      check("lockAlarm", lockAlarm, 1'b1);
      spinEn = 1'b1;
      afterEdge(1'b1, 8, 1'b0, 1'b0);
   endtask

   task automatic reportAndStop;
      $display("comparisons %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      tick(4);
      coils(1'b0, 1'b0);
      check("alarmSwitch", alarmSwitch, 1'b0);
      tick(4);
      nrst = 1'b1;
      tStartup;
      tOffTime;
      tHot;
      tLock;
      reportAndStop;
   end
   // Legal run is about 80k cycles: one hot tone period plus one lock tone burst
   initial begin
      repeat (110000) @(posedge clk_sys);
      numErrors++;
      reportAndStop;
   end
endmodule // test_bfoc_fan_ctrl
